/* File: core/asr_rx.sv */
// Asynchronous serial receiver: bit recovery, framing, buffering and flags

// Overview of operation
// [RULE1] A falling edge on the line starts a character; start bit is zero.
// [RULE2] Half a bit after the edge, the line must still be low.
// [RULE3] A high mid-start sample drops the character silently, back to hunting.
// [RULE4] Then each bit centre a full bit apart, majority voted, shifted in.
// [RULE5] One more bit later sample stop; zero sets framing error, one clears.
// [RULE6] Completed character moves into the buffer and raises the receive flag.
// [RULE7] Reading the data register returns and removes the oldest character.
// [RULE8] After an overrun no further characters are taken until it clears.
// [RULE9] Receive flag is high exactly while enabled and the buffer holds data.
// [RULE10] Receive flag is read-only and follows only occupancy and enable.
// [RULE11] Interrupt needs the flag plus receive, peripheral and global enables.
// [RULE12] Interrupt enables mask only the interrupt, never the flag.
// [RULE13] Nine-bit option captures nine bits; ninth and errors shown as status.
// [RULE14] Clearing continuous receive enable clears the overrun flag.
// [RULE15] Nine-bit address detect keeps only characters whose ninth bit is one.
// [RULE16] In address-detect mode every buffered ninth bit reads as one.
// [RULE17] Address detect off again accepts every character whatever its ninth bit.
// [RULE18] Software sets port enable, continuous receive, and keeps sync clear.
// [RULE19] Software programs divisor and speed selects before enabling reception.
// [RULE20] Data register read gives the eight low data bits of the oldest.
// [RULE21] Bit recovery oversamples at sixteen times the bit rate.
// [RULE22] Buffer holds two characters while a third is shifted in.
// [RULE23] Continuous receive enable turns the receiver on; clearing stops it.
// [RULE24] Low-speed narrow divisor: bit period is 64 times divisor plus one.
// [RULE25] Character completing into a full buffer sets overrun and is dropped.
module asr_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Serial line
  input wire logic rx_pin,
  // Receiver control
  input wire logic serial_port_enable,
  input wire logic continuous_receive_enable,
  input wire logic sync_mode_select,
  input wire logic ninth_bit_enable,
  input wire logic address_detect_enable,
  // Baud configuration
  input wire logic high_speed_select,
  input wire logic wide_divisor_select,
  input wire logic [7:0] baud_divisor_high,
  input wire logic [7:0] baud_divisor_low,
  // Interrupt enables
  input wire logic receive_irq_enable,
  input wire logic peripheral_irq_gate,
  input wire logic global_irq_gate,
  // Data register access
  input wire logic data_read,
  output logic [asr_pkg::DATA_W-1:0] receive_data,
  // Status
  output logic receive_ninth_bit,
  output logic framing_error,
  output logic overrun_error_flag,
  output logic receive_char_flag,
  output logic receive_irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic maj3(input logic [asr_pkg::VOTE_TAPS-1:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj3

  function automatic logic [2:0] period_shift(input logic hs, input logic wide);
    unique case ({hs, wide})
      2'b00: period_shift = asr_pkg::SHIFT_LOW_NARROW;
      2'b01: period_shift = asr_pkg::SHIFT_LOW_WIDE;
      2'b10: period_shift = asr_pkg::SHIFT_HIGH_NARROW;
      2'b11: period_shift = asr_pkg::SHIFT_HIGH_WIDE;
    endcase
  endfunction : period_shift

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic rx_meta_reg, rx_meta_next;
  logic rx_sync_reg, rx_sync_next;
  logic rx_prev_reg, rx_prev_next;
  asr_pkg::asr_state_e state_reg, state_next;
  logic [asr_pkg::PERIOD_W-1:0] cnt_reg, cnt_next;
  logic [asr_pkg::BITCNT_W-1:0] bits_reg, bits_next;
  logic [asr_pkg::SHIFT_W-1:0] receive_shift_register, receive_shift_next;
  logic [asr_pkg::VOTE_TAPS-1:0] votes_reg, votes_next;
  logic overrun_reg, overrun_next;

  logic rx_enabled;
  logic falling_edge;
  logic [asr_pkg::DIV_W-1:0] baud_divisor_value;
  logic [asr_pkg::PERIOD_W-1:0] bit_period;
  logic [asr_pkg::PERIOD_W-1:0] bit_last;
  logic [asr_pkg::PERIOD_W-1:0] half_last;
  logic [asr_pkg::PERIOD_W-1:0] tick;
  logic [asr_pkg::VOTE_TAPS-1:0] tap_hit;
  logic bit_value;
  logic [asr_pkg::BITCNT_W-1:0] bits_needed;
  logic [asr_pkg::DATA_W-1:0] char_data;
  logic char_ninth;
  logic char_accept;

  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [asr_pkg::ENTRY_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic [asr_pkg::ENTRY_W-1:0] fifo_out_data;

  // ----------------------------------------------------------------
  // Enable and line edge
  // ----------------------------------------------------------------
  // Enable needs port enable and continuous receive, async mode only
  assign rx_enabled = serial_port_enable && continuous_receive_enable && !sync_mode_select;
  // Edge detect on start
  assign falling_edge = rx_prev_reg && !rx_sync_reg;

  // Two-stage synchroniser plus one history stage for the edge detector
  always_comb begin
    rx_meta_next = rx_pin;
    rx_sync_next = rx_meta_reg;
    rx_prev_next = rx_sync_reg;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_meta_reg <= asr_pkg::RX_IDLE_LEVEL;
      rx_sync_reg <= asr_pkg::RX_IDLE_LEVEL;
      rx_prev_reg <= asr_pkg::RX_IDLE_LEVEL;
    end else if (clk_en) begin
      rx_meta_reg <= rx_meta_next;
      rx_sync_reg <= rx_sync_next;
      rx_prev_reg <= rx_prev_next;
    end
  end

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  assign baud_divisor_value = wide_divisor_select ?
                              {baud_divisor_high, baud_divisor_low} :
                              {{(asr_pkg::DIV_W - asr_pkg::DIV_LOW_W){1'b0}}, baud_divisor_low};
  // Period scaling by speed mode
  assign bit_period = (asr_pkg::PERIOD_W'(baud_divisor_value) + asr_pkg::PERIOD_W'(1))
                      << period_shift(high_speed_select, wide_divisor_select);
  assign bit_last = asr_pkg::PERIOD_W'(bit_period - asr_pkg::PERIOD_W'(1));
  assign half_last = asr_pkg::PERIOD_W'((bit_period >> 1) - asr_pkg::PERIOD_W'(1));
  // Oversample tick spacing
  assign tick = bit_period >> asr_pkg::OVERSAMPLE_SHIFT;

  // Vote taps sit at the centre and one and two ticks before it, so the
  // decision lands on the centre without reaching into the next bit.
  // At the fastest setting the tick is below one clock and all taps merge.
  genvar k;
  generate
    for (k = 0; k < asr_pkg::VOTE_TAPS; k++) begin : g_tap
      assign tap_hit[k] = (cnt_reg == asr_pkg::PERIOD_W'(bit_last
                           - asr_pkg::PERIOD_W'(asr_pkg::PERIOD_W'(k) * tick)));
    end
  endgenerate

  // ----------------------------------------------------------------
  // Character assembly
  // ----------------------------------------------------------------
  assign bits_needed = ninth_bit_enable ? asr_pkg::BITS_WIDE : asr_pkg::BITS_NARROW;
  // Nine-bit capture
  assign char_ninth = ninth_bit_enable && receive_shift_register[asr_pkg::SHIFT_NINTH];
  assign char_data = ninth_bit_enable ?
                     receive_shift_register[asr_pkg::DATA_W-1:0] :
                     receive_shift_register[asr_pkg::SHIFT_W-1:1];
  // Address filter
  assign char_accept = !(ninth_bit_enable && address_detect_enable && !char_ninth);

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = asr_pkg::PERIOD_W'(cnt_reg + asr_pkg::PERIOD_W'(1));
    bits_next = bits_reg;
    receive_shift_next = receive_shift_register;
    votes_next = votes_reg;
    overrun_next = overrun_reg;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    bit_value = 1'b1;

    for (int i = 0; i < asr_pkg::VOTE_TAPS; i++) begin
      if (tap_hit[i]) begin
        votes_next[i] = rx_sync_reg;
      end
    end
    bit_value = maj3(votes_next);

    unique case (state_reg)
      asr_pkg::ASR_IDLE: begin
        cnt_next = asr_pkg::CNT_RESET;
        // [RULE1] Hunt for edge
        // [RULE8] Overrun blocks start
        if (falling_edge && !overrun_reg) begin
          state_next = asr_pkg::ASR_START;
          cnt_next = asr_pkg::PERIOD_W'(1);
        end
      end
      asr_pkg::ASR_START: begin
        // [RULE2] Mid-start check
        if (cnt_reg == half_last) begin
          cnt_next = asr_pkg::CNT_RESET;
          bits_next = asr_pkg::BITS_RESET;
          if (rx_sync_reg) begin
            // [RULE3] Silent abort
            state_next = asr_pkg::ASR_IDLE;
          end else begin
            state_next = asr_pkg::ASR_DATA;
          end
        end
      end
      asr_pkg::ASR_DATA: begin
        // [RULE4] Vote and shift
        // [RULE21] Oversampled bit centres
        if (cnt_reg == bit_last) begin
          cnt_next = asr_pkg::CNT_RESET;
          receive_shift_next = {bit_value, receive_shift_register[asr_pkg::SHIFT_W-1:1]};
          bits_next = asr_pkg::BITCNT_W'(bits_reg + 1'b1);
          if (asr_pkg::BITCNT_W'(bits_reg + 1'b1) == bits_needed) begin
            state_next = asr_pkg::ASR_STOP;
          end
        end
      end
      asr_pkg::ASR_STOP: begin
        if (cnt_reg == bit_last) begin
          cnt_next = asr_pkg::CNT_RESET;
          state_next = asr_pkg::ASR_IDLE;
          // [RULE5] Stop framing check
          fifo_in_data[asr_pkg::ENTRY_FERR] = !bit_value;
          // [RULE16] Ninth bit kept
          fifo_in_data[asr_pkg::ENTRY_NINTH] = char_ninth;
          fifo_in_data[asr_pkg::ENTRY_DATA_LSB +: asr_pkg::DATA_W] = char_data;
          // [RULE15] Address filter
          // [RULE17] Filter released
          if (char_accept) begin
            // [RULE6] Push to buffer
            fifo_in_valid = fifo_in_ready;
            // [RULE25] Full buffer overruns
            if (!fifo_in_ready) begin
              overrun_next = 1'b1;
            end
          end
        end
      end
    endcase

    // [RULE23] Receiver enable gate
    if (!rx_enabled) begin
      state_next = asr_pkg::ASR_IDLE;
      cnt_next = asr_pkg::CNT_RESET;
      fifo_in_valid = 1'b0;
    end
    // [RULE14] Overrun clear
    if (!continuous_receive_enable) begin
      overrun_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= asr_pkg::ASR_IDLE;
      cnt_reg <= asr_pkg::CNT_RESET;
      bits_reg <= asr_pkg::BITS_RESET;
      receive_shift_register <= asr_pkg::SHIFT_RESET;
      votes_reg <= asr_pkg::VOTES_RESET;
      overrun_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bits_reg <= bits_next;
      receive_shift_register <= receive_shift_next;
      votes_reg <= votes_next;
      overrun_reg <= overrun_next;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  // [RULE22] Two-entry buffer
  // [RULE7] Read pops oldest
  asr_fifo #(
    .WIDTH(asr_pkg::ENTRY_W),
    .DEPTH(asr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(data_read),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Data and status outputs
  // ----------------------------------------------------------------
  // [RULE20] Low eight bits
  assign receive_data = fifo_out_data[asr_pkg::ENTRY_DATA_LSB +: asr_pkg::DATA_W];
  // [RULE13] Ninth bit and errors
  assign receive_ninth_bit = fifo_out_data[asr_pkg::ENTRY_NINTH];
  assign framing_error = fifo_out_data[asr_pkg::ENTRY_FERR];
  assign overrun_error_flag = overrun_reg;

  // ----------------------------------------------------------------
  // Flag and interrupt
  // ----------------------------------------------------------------
  // [RULE9] Flag from occupancy
  // [RULE10] No software write path
  // [RULE12] Flag ignores enables
  assign receive_char_flag = rx_enabled && fifo_out_valid;
  // [RULE11] Three-way gate
  assign receive_irq = receive_char_flag && receive_irq_enable
                       && peripheral_irq_gate && global_irq_gate;

endmodule : asr_rx

/* File: core/asr_pkg.sv */
// Shared constants and types for the asynchronous serial receiver
package asr_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int SHIFT_W = 9;
  localparam int ENTRY_W = 10;
  localparam int FIFO_DEPTH = 2;
  localparam int DIV_W = 16;
  localparam int DIV_LOW_W = 8;
  localparam int PERIOD_W = 23;
  localparam int BITCNT_W = 4;
  localparam int VOTE_TAPS = 3;

  // ----------------------------------------------------------------
  // Field positions inside a buffered character
  // ----------------------------------------------------------------
  localparam int ENTRY_DATA_LSB = 0;
  localparam int ENTRY_NINTH = 8;
  localparam int ENTRY_FERR = 9;
  localparam int SHIFT_NINTH = 8;

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  // Oversampling at sixteen times the bit rate: one tick is period >> 4
  localparam int OVERSAMPLE_SHIFT = 4;
  // Bit period = (divisor + 1) << shift, per speed and divisor mode
  localparam logic [2:0] SHIFT_LOW_NARROW = 3'h6;
  localparam logic [2:0] SHIFT_LOW_WIDE = 3'h4;
  localparam logic [2:0] SHIFT_HIGH_NARROW = 3'h4;
  localparam logic [2:0] SHIFT_HIGH_WIDE = 3'h2;
  localparam logic [BITCNT_W-1:0] BITS_NARROW = 4'h8;
  localparam logic [BITCNT_W-1:0] BITS_WIDE = 4'h9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RX_IDLE_LEVEL = 1'b1;
  localparam logic [PERIOD_W-1:0] CNT_RESET = 23'h000000;
  localparam logic [BITCNT_W-1:0] BITS_RESET = 4'h0;
  localparam logic [SHIFT_W-1:0] SHIFT_RESET = 9'h000;
  localparam logic [VOTE_TAPS-1:0] VOTES_RESET = 3'h7;

  // ----------------------------------------------------------------
  // Receiver states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASR_IDLE,
    ASR_START,
    ASR_DATA,
    ASR_STOP
  } asr_state_e;

endpackage : asr_pkg

/* File: core/asr_fifo.sv */
// Two-entry receive buffer with valid and ready on both sides
module asr_fifo #(
  parameter int WIDTH = asr_pkg::ENTRY_W,
  parameter int DEPTH = asr_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic do_push;
  logic do_pop;

  assign in_ready = (count_reg != FULL_CNT);
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_ready && out_valid;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (do_push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next = (wr_ptr_reg == LAST_PTR) ? '0 : PTR_W'(wr_ptr_reg + 1'b1);
    end
    if (do_pop) begin
      rd_ptr_next = (rd_ptr_reg == LAST_PTR) ? '0 : PTR_W'(rd_ptr_reg + 1'b1);
    end
    if (do_push && !do_pop) begin
      count_next = CNT_W'(count_reg + 1'b1);
    end else if (do_pop && !do_push) begin
      count_next = CNT_W'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (clk_en) begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule : asr_fifo

/* File: testbench/asr_rx_properties.sv */
// Port-level concurrent checks for the serial receiver
module asr_rx_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Controls
  input wire logic serial_port_enable,
  input wire logic continuous_receive_enable,
  input wire logic sync_mode_select,
  input wire logic ninth_bit_enable,
  input wire logic address_detect_enable,
  input wire logic receive_irq_enable,
  input wire logic peripheral_irq_gate,
  input wire logic global_irq_gate,
  input wire logic data_read,
  // Results
  input wire logic [7:0] receive_data,
  input wire logic receive_ninth_bit,
  input wire logic overrun_error_flag,
  input wire logic receive_char_flag,
  input wire logic receive_irq
);
  logic en_w;

  assign en_w = serial_port_enable & continuous_receive_enable & ~sync_mode_select;

  default clocking main_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence flag_drop_s;
    $fell(receive_char_flag) && en_w;
  endsequence
  sequence ovr_set_s;
    $rose(overrun_error_flag);
  endsequence
  sequence push_s;
    $rose(receive_char_flag) && ninth_bit_enable;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  flag_needs_enable_a: assert property (receive_char_flag |-> en_w)
    else $error("receive flag high while receiver off");
  flag_drop_cause_a: assert property (flag_drop_s |-> $past(data_read && clk_en))
    else $error("receive flag fell without a read");
  reset_clears_a: assert property (disable iff (1'b0)
    !rst_n |=> !receive_char_flag && !overrun_error_flag && receive_data == 8'h00)
    else $error("state not cleared by reset");
  overrun_holds_a: assert property (
    overrun_error_flag && continuous_receive_enable |=> overrun_error_flag)
    else $error("overrun flag dropped while receive enabled");
  overrun_clears_a: assert property (
    !continuous_receive_enable && clk_en |=> !overrun_error_flag)
    else $error("overrun flag kept after receive disable");
  overrun_cause_a: assert property (ovr_set_s |-> $past(receive_char_flag))
    else $error("overrun set with empty buffer");
  irq_gating_a: assert property (receive_irq == (receive_char_flag
    && receive_irq_enable && peripheral_irq_gate && global_irq_gate))
    else $error("interrupt request not flag and gates");
  addr_ninth_a: assert property (
    push_s and address_detect_enable |-> receive_ninth_bit)
    else $error("address mode buffered a zero ninth bit");
  narrow_ninth_a: assert property (
    $rose(receive_char_flag) && !ninth_bit_enable |-> !receive_ninth_bit)
    else $error("ninth bit set in eight bit mode");
endmodule : asr_rx_properties

bind asr_rx asr_rx_properties asr_rx_properties_inst (.clk, .rst_n, .clk_en,
  .serial_port_enable, .continuous_receive_enable, .sync_mode_select, .ninth_bit_enable,
  .address_detect_enable, .receive_irq_enable, .peripheral_irq_gate, .global_irq_gate,
  .data_read, .receive_data, .receive_ninth_bit, .overrun_error_flag, .receive_char_flag,
  .receive_irq);

/* File: testbench/asr_line_model.sv */
// Remote serial transmitter that drives the receive line
module asr_line_model (
  // Clock
  input wire logic clk,
  // Serial line, idles high
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial rx_pin = 1'b1;

  // ------------------------------------------------------------
  // Frame and glitch drivers
  // ------------------------------------------------------------
  task automatic send(input logic [8:0] d, input int nb, input int per, input logic stp,
                      input int gap);
    int i;
    @(posedge clk);
    rx_pin <= 1'b0;
    repeat (per) @(posedge clk);
    for (i = 0; i < nb; i++) begin
      rx_pin <= d[i];
      repeat (per) @(posedge clk);
    end
    rx_pin <= stp;
    repeat (per) @(posedge clk);
    rx_pin <= 1'b1;
    repeat (gap) @(posedge clk);
  endtask : send

  // Short low pulse, too short to survive the mid-start check
  task automatic glitch(input int lo, input int hi);
    @(posedge clk);
    rx_pin <= 1'b0;
    repeat (lo) @(posedge clk);
    rx_pin <= 1'b1;
    repeat (hi) @(posedge clk);
  endtask : glitch
endmodule : asr_line_model

/* File: testbench/asr_rx_test.sv */
// Self-checking bench for the asynchronous serial receiver
module asr_rx_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst_n, clk_en, rx_pin, serial_port_enable, continuous_receive_enable;
  logic sync_mode_select, ninth_bit_enable, address_detect_enable;
  logic high_speed_select, wide_divisor_select, receive_irq_enable;
  logic peripheral_irq_gate, global_irq_gate, data_read, rd_en;
  logic [7:0] baud_divisor_high, baud_divisor_low, receive_data;
  logic receive_ninth_bit, framing_error, overrun_error_flag, receive_char_flag, receive_irq;
  logic [9:0] exp_q[$];
  logic [31:0] lfsr;
  int n_mismatch, checked, per;

  asr_rx asr_rx_inst (.clk, .rst_n, .clk_en, .rx_pin, .serial_port_enable,
    .continuous_receive_enable, .sync_mode_select, .ninth_bit_enable, .address_detect_enable,
    .high_speed_select, .wide_divisor_select, .baud_divisor_high, .baud_divisor_low,
    .receive_irq_enable, .peripheral_irq_gate, .global_irq_gate, .data_read, .receive_data,
    .receive_ninth_bit, .framing_error, .overrun_error_flag, .receive_char_flag, .receive_irq);
  asr_line_model asr_line_model_inst (.clk, .rx_pin);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check_char(input string name, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : check_char

  task automatic check_bit(input string name, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", name, e, g);
    end
  endtask : check_bit

  task automatic stop_test();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  function automatic void rnd(output logic [8:0] v);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    v = lfsr[8:0];
  endfunction : rnd

  // Note the expected entry first, then put the frame on the line
  task automatic tx(input logic [8:0] d, input logic stp, input logic keep, input int gap);
    @(posedge clk);
    if (keep) exp_q.push_back({~stp, ninth_bit_enable & d[8], d[7:0]});
    asr_line_model_inst.send(d, ninth_bit_enable ? 9 : 8, per, stp, gap);
  endtask : tx

  // Bounded wait until every noted entry has been read back
  task automatic drain();
    int i;
    for (i = 0; i < 400 && (exp_q.size() != 0 || receive_char_flag !== 1'b0); i++) begin
      @(posedge clk);
    end
    check_bit("drained", 1'b1, exp_q.size() == 0);
  endtask : drain

  // ------------------------------------------------------------
  // Reader: pops when the flag shows, compares with oldest note
  // ------------------------------------------------------------
  always @(posedge clk) begin
    data_read <= (rd_en && receive_char_flag === 1'b1 && !data_read);
    if (rd_en && receive_char_flag === 1'b1 && !data_read) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("wrong value char expected none seen %h", receive_data);
      end else begin
        check_char("char", exp_q.pop_front(), // Head
          {framing_error, receive_ninth_bit, receive_data});
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin : watchdog
    repeat (30000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial begin : main
    int m;
    logic [8:0] v;
    {rst_n, sync_mode_select, ninth_bit_enable, address_detect_enable} = '0;
    {receive_irq_enable, peripheral_irq_gate, global_irq_gate, baud_divisor_high} = '0;
    {high_speed_select, wide_divisor_select, baud_divisor_low} = 10'h001;
    {clk_en, serial_port_enable, continuous_receive_enable, rd_en} = 4'hF;
    lfsr = 32'hE7E4EB36;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Every speed and divisor mode, divisor one
    for (m = 0; m < 4; m++) begin
      @(posedge clk);
      {high_speed_select, wide_divisor_select} <= m[1:0];
      per = 2 << ((m == 0) ? 6 : (m == 3) ? 2 : 4);
      rnd(v);
      tx(v, 1'b1, 1'b1, per); // Period per mode
      drain();
    end
    @(posedge clk);
    baud_divisor_low <= 8'h03;
    per = 16;
    // Back to back frames, bad stop on every other one
    for (m = 0; m < 6; m++) begin
      rnd(v);
      tx(v, m[0], 1'b1, m[0] ? 0 : per); // Framing
    end
    drain();
    asr_line_model_inst.glitch(per / 4, 2 * per); // False start
    drain();
    ninth_bit_enable <= 1'b1;
    for (m = 0; m < 2; m++) begin
      rnd(v);
      tx({m[0], v[7:0]}, 1'b1, 1'b1, per); // Nine bits
    end
    drain();
    address_detect_enable <= 1'b1;
    rnd(v);
    tx({1'b0, v[7:0]}, 1'b1, 1'b0, per); // Filtered out
    rnd(v);
    tx({1'b1, v[7:0]}, 1'b1, 1'b1, per); // Address kept
    drain();
    address_detect_enable <= 1'b0;
    rnd(v);
    tx({1'b0, v[7:0]}, 1'b1, 1'b1, per); // All accepted
    drain();
    ninth_bit_enable <= 1'b0;
    rd_en <= 1'b0;
    // Stalled reader: two stored, third overruns, fourth refused
    for (m = 0; m < 4; m++) begin
      rnd(v);
      tx(v, 1'b1, m < 2, 0); // Overrun
    end
    repeat (per) @(posedge clk);
    check_bit("overrun", 1'b1, overrun_error_flag); // Set
    for (m = 0; m < 8; m++) begin
      @(posedge clk);
      {receive_irq_enable, peripheral_irq_gate, global_irq_gate} <= m[2:0];
      @(posedge clk);
      check_bit("irq", &m[2:0], receive_irq); // Gated
      check_bit("flag", 1'b1, receive_char_flag); // Unmasked
    end
    sync_mode_select <= 1'b1;
    repeat (2) @(posedge clk);
    check_bit("flag", 1'b0, receive_char_flag); // Sync mode off
    sync_mode_select <= 1'b0;
    // Frozen clock enable must hold the overrun flag
    clk_en <= 1'b0;
    continuous_receive_enable <= 1'b0;
    repeat (2) @(posedge clk);
    check_bit("overrun", 1'b1, overrun_error_flag); // Frozen
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    check_bit("flag", 1'b0, receive_char_flag); // Disabled
    check_bit("overrun", 1'b0, overrun_error_flag); // Cleared
    continuous_receive_enable <= 1'b1;
    rd_en <= 1'b1;
    drain();
    rnd(v);
    tx(v, 1'b1, 1'b1, per); // Resumed
    drain();
    stop_test();
  end
endmodule : asr_rx_test
